// [clock_gear_map.svh]
// Register offsets, field positions and reset values of the clock gear block
`ifndef CLOCK_GEAR_MAP_SVH
`define CLOCK_GEAR_MAP_SVH

// ==========================================================================
// Address map (byte offsets from the block base)
`define CG_BASE_ADDR 32'h400F_3000
`define CG_ADDR_W 12
`define CG_SYSCTL_OFS 12'h000
`define CG_OSC_OFS 12'h004
`define CG_STBY_OFS 12'h008
`define CG_PLLSEL_OFS 12'h00C
`define CG_USBCTL_OFS 12'h038
`define CG_PROTECT_OFS 12'h03C
`define CG_AUX_COUNT 5

// ==========================================================================
// System clock control fields
`define SYS_ADCSTOP_BIT 20
`define SYS_CLKOUT_MSB 17
`define SYS_CLKOUT_LSB 16
`define SYS_SPARE_BIT 13
`define SYS_PSRC_BIT 12
`define SYS_PRESC_MSB 10
`define SYS_PRESC_LSB 8
`define SYS_GEAR_MSB 2
`define SYS_GEAR_LSB 0
`define SYS_WR_MASK 32'h0013_3707
`define SYS_RESET 32'h0001_0000
`define AUX_RESET 32'h0000_0000

`endif

// [clock_gear_pkg.sv]
// Types shared by the clock gear block
`default_nettype none
package clock_gear_pkg;

  // ========================================================================
  // Field encodings
  typedef enum logic [1:0] {
    CLKOUT_RSVD0 = 2'b00,
    CLKOUT_HALF = 2'b01,
    CLKOUT_FULL = 2'b10,
    CLKOUT_RSVD3 = 2'b11
  } clkout_sel_t;

  typedef enum logic [2:0] {
    GEAR_DIV1 = 3'b000,
    GEAR_DIV2 = 3'b100,
    GEAR_DIV4 = 3'b101,
    GEAR_DIV8 = 3'b110,
    GEAR_DIV16 = 3'b111
  } gear_code_t;

  typedef enum logic [2:0] {
    PRESC_DIV1 = 3'b000,
    PRESC_DIV2 = 3'b001,
    PRESC_DIV4 = 3'b010,
    PRESC_DIV8 = 3'b011,
    PRESC_DIV16 = 3'b100,
    PRESC_DIV32 = 3'b101
  } presc_code_t;

endpackage : clock_gear_pkg
`default_nettype wire

// [clock_gear.sv]
// Clock gear, peripheral prescaler, clock output and ADC clock gate
`timescale 1ns/1ns
`default_nettype none
`include "clock_gear_map.svh"
// Function
// - ADC clock stops while stop bit is one
// - ADC clock stop bit clear after reset
// - Clock output select: 01 half, 10 full
// - Peripheral source: 0 gear, 1 undivided
// - Undivided source ignores gear divider setting
// - Prescaler divides by 1 to 32
// - Gear divides by 1,2,4,8,16
// - Registers decoded at fixed offsets from base

module clock_gear
  import clock_gear_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic system_clock_en,
  output logic peripheral_clock_en,
  output logic prescale_clock_en,
  output logic clock_output_pin,
  output logic adc_clock_en
);

  // ========================================================================
  // Register state
  logic [31:0] sys_q;
  logic [31:0] aux_q [`CG_AUX_COUNT];
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic pready_q;
  logic pslverr_q;
  logic err_d;
  logic setup_cyc;
  logic wr_fire;
  logic wr_sys;
  logic aux_hit;
  logic [2:0] aux_idx;

  // Decoded fields
  logic adc_stop;
  clkout_sel_t clkout_sel;
  logic psrc_fc;
  logic [2:0] presc_code;
  logic [2:0] gear_code;

  // Divider state
  logic [3:0] gear_cnt_q;
  logic [3:0] gear_lim;
  logic gear_tick;
  logic [4:0] presc_cnt_q;
  logic [4:0] presc_lim;
  logic periph_tick;
  logic presc_tick;
  logic half_q;

  // Output flops
  logic sys_en_q;
  logic periph_en_q;
  logic presc_en_q;
  logic clkout_q;
  logic adc_en_q;

  // ========================================================================
  // Field extraction
  assign adc_stop = sys_q[`SYS_ADCSTOP_BIT];
  assign clkout_sel = clkout_sel_t'(sys_q[`SYS_CLKOUT_MSB:`SYS_CLKOUT_LSB]);
  assign psrc_fc = sys_q[`SYS_PSRC_BIT];
  assign presc_code = sys_q[`SYS_PRESC_MSB:`SYS_PRESC_LSB];
  assign gear_code = sys_q[`SYS_GEAR_MSB:`SYS_GEAR_LSB];

  // ========================================================================
  // APB slave
  // Setup cycle decodes; the access phase always completes in its first cycle
  assign setup_cyc = psel && !penable;
  assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wr_sys = wr_fire && (paddr == `CG_SYSCTL_OFS);

  // Map the storage-only registers onto one small array
  always_comb begin
    aux_hit = 1'b1;
    aux_idx = 3'h0;
    case (paddr)
      `CG_OSC_OFS: aux_idx = 3'h0;
      `CG_STBY_OFS: aux_idx = 3'h1;
      `CG_PLLSEL_OFS: aux_idx = 3'h2;
      `CG_USBCTL_OFS: aux_idx = 3'h3;
      `CG_PROTECT_OFS: aux_idx = 3'h4;
      default: aux_hit = 1'b0;
    endcase
  end

  // Read mux; reserved and unmapped words read zero and flag an error
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `CG_SYSCTL_OFS) begin
      rd_d = sys_q & `SYS_WR_MASK;
    end else if (aux_hit) begin
      rd_d = aux_q[aux_idx];
    end else begin
      err_d = 1'b1;
    end
  end

  // Answer flops: loaded at the setup edge, dropped after the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_cyc;
      if (setup_cyc) begin
        pslverr_q <= err_d;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // System clock control; only documented bits ever store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_q <= `SYS_RESET;
    end else if (wr_sys) begin
      sys_q <= pwdata & `SYS_WR_MASK;
    end
  end

  // Oscillator, standby, PLL, USB and protect words are plain storage here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `CG_AUX_COUNT; i++) begin
        aux_q[i] <= `AUX_RESET;
      end
    end else if (wr_fire && aux_hit) begin
      aux_q[aux_idx] <= pwdata;
    end
  end

  // ========================================================================
  // Clock gear divider
  // Reserved gear codes run undivided rather than stall the system
  always_comb begin
    unique case (gear_code)
      GEAR_DIV2: gear_lim = 4'h1;
      GEAR_DIV4: gear_lim = 4'h3;
      GEAR_DIV8: gear_lim = 4'h7;
      GEAR_DIV16: gear_lim = 4'hF;
      default: gear_lim = 4'h0;
    endcase
  end

  // Compare with >= so a shorter ratio written mid-count wraps at once
  assign gear_tick = (gear_cnt_q >= gear_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_cnt_q <= 4'h0;
    end else if (gear_tick) begin
      gear_cnt_q <= 4'h0;
    end else begin
      gear_cnt_q <= gear_cnt_q + 4'h1;
    end
  end

  // ========================================================================
  // Peripheral source and prescaler
  // Undivided source ticks every cycle whatever the gear says
  assign periph_tick = psrc_fc ? 1'b1 : gear_tick;

  // Reserved prescaler codes pass the peripheral rate through
  always_comb begin
    unique case (presc_code)
      PRESC_DIV2: presc_lim = 5'h01;
      PRESC_DIV4: presc_lim = 5'h03;
      PRESC_DIV8: presc_lim = 5'h07;
      PRESC_DIV16: presc_lim = 5'h0F;
      PRESC_DIV32: presc_lim = 5'h1F;
      default: presc_lim = 5'h00;
    endcase
  end

  assign presc_tick = periph_tick && (presc_cnt_q >= presc_lim);

  // Counts peripheral ticks only, so the prescaler rides on the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_q <= 5'h00;
    end else if (presc_tick) begin
      presc_cnt_q <= 5'h00;
    end else if (periph_tick) begin
      presc_cnt_q <= presc_cnt_q + 5'h01;
    end
  end

  // ========================================================================
  // Clock output pin
  // Half-rate phase toggles on every system tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else if (gear_tick) begin
      half_q <= !half_q;
    end
  end

  // Pin carries one pulse per selected period; reserved codes hold it low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkout_q <= 1'b0;
    end else begin
      unique case (clkout_sel)
        CLKOUT_HALF: clkout_q <= gear_tick && half_q;
        CLKOUT_FULL: clkout_q <= gear_tick;
        CLKOUT_RSVD0: clkout_q <= 1'b0;
        CLKOUT_RSVD3: clkout_q <= 1'b0;
      endcase
    end
  end

  // ========================================================================
  // Enable outputs
  // Every output leaves a flop, so each enable lags its tick by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_en_q <= 1'b0;
      periph_en_q <= 1'b0;
      presc_en_q <= 1'b0;
    end else begin
      sys_en_q <= gear_tick;
      periph_en_q <= periph_tick;
      presc_en_q <= presc_tick;
    end
  end

  // ADC clock gate; software must have halted conversions before stopping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_en_q <= 1'b0;
    end else begin
      adc_en_q <= !adc_stop;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign system_clock_en = sys_en_q;
  assign peripheral_clock_en = periph_en_q;
  assign prescale_clock_en = presc_en_q;
  assign clock_output_pin = clkout_q;
  assign adc_clock_en = adc_en_q;

  // ========================================================================
  // Assertions
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Stop bit gates the ADC clock from the next cycle
  a_adc_gate_off: assert property (adc_stop |=> !adc_clock_en)
    else $error("ADC clock running while stopped");
  a_adc_gate_on: assert property (presetn && !adc_stop |=> adc_clock_en)
    else $error("ADC clock missing while enabled");

  // Reset value is in place when reset releases
  a_reset_value: assert property (@(posedge pclk)
    $rose(presetn) |-> (sys_q == `SYS_RESET) && !adc_stop)
    else $error("System control reset value wrong");

  // Full rate output follows every system tick
  a_clkout_full: assert property
    ((clkout_sel == CLKOUT_FULL) && gear_tick |=> clock_output_pin)
    else $error("Full rate clock output missed a tick");
  // Half rate output skips alternate ticks
  a_clkout_half: assert property
    ((clkout_sel == CLKOUT_HALF) && gear_tick && !half_q |=> !clock_output_pin)
    else $error("Half rate clock output on wrong phase");
  a_clkout_rsvd: assert property
    ((clkout_sel == CLKOUT_RSVD0) |=> !clock_output_pin)
    else $error("Clock output active on reserved code");

  // Undivided source pulses every cycle even when the gear divides
  a_periph_fc: assert property
    (psrc_fc && (gear_code == GEAR_DIV16) |=> peripheral_clock_en)
    else $error("Undivided peripheral clock depends on gear");
  a_periph_gear: assert property
    (!psrc_fc |=> (peripheral_clock_en == system_clock_en))
    else $error("Peripheral clock not following gear");

  // Prescaler pass-through and divide-by-two spacing
  a_presc_div1: assert property
    ((presc_code == PRESC_DIV1) |-> (presc_tick == periph_tick))
    else $error("Prescaler not passing peripheral rate");
  a_presc_div2: assert property
    ((presc_code == PRESC_DIV2) && presc_tick ##1 (presc_code == PRESC_DIV2) && periph_tick
     |-> !presc_tick ##1 (presc_tick || !periph_tick || (presc_code != PRESC_DIV2)))
    else $error("Prescaler by two spacing wrong");

  // Gear spacing: undivided every cycle, by two every other
  a_gear_div1: assert property ((gear_code == GEAR_DIV1) |-> gear_tick)
    else $error("Undivided gear missed a cycle");
  a_gear_div2: assert property
    ((gear_code == GEAR_DIV2) && gear_tick ##1 (gear_code == GEAR_DIV2)
     |-> !gear_tick ##1 (gear_tick || (gear_code != GEAR_DIV2)))
    else $error("Gear by two spacing wrong");

  // Bus answers in the first access cycle; reserved words flag an error
  a_apb_ready: assert property (setup_cyc |=> pready)
    else $error("Access phase not answered at once");
  a_apb_rsvd: assert property
    (setup_cyc && (paddr == 12'h010) |=> pslverr && (prdata == 32'h0000_0000))
    else $error("Reserved location not refused");

  // Writes store the masked value; the spare bit is inside the mask and stores what is written
  a_sys_write: assert property
    (wr_sys |=> (sys_q == ($past(pwdata) & `SYS_WR_MASK)))
    else $error("System control write stored wrong value");
  a_sys_hold: assert property (setup_cyc && (paddr != `CG_SYSCTL_OFS)
    ##1 pready |=> $stable(sys_q))
    else $error("System control changed by another address");

endmodule : clock_gear
`default_nettype wire

// [tb.sv]
// Self-checking bench for the clock gear register block
`timescale 1ns/1ns
`default_nettype none
`include "clock_gear_map.svh"

module tb
  import clock_gear_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`CG_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic system_clock_en;
  logic peripheral_clock_en;
  logic prescale_clock_en;
  logic clock_output_pin;
  logic adc_clock_en;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cycle = 0;
  int cnt;
  logic [31:0] rd;
  logic er;
  logic [11:0] aux_ofs [5] = '{`CG_OSC_OFS, `CG_STBY_OFS, `CG_PLLSEL_OFS, `CG_USBCTL_OFS,
    `CG_PROTECT_OFS};
  logic [2:0] gear_codes [5] = '{GEAR_DIV1, GEAR_DIV2, GEAR_DIV4, GEAR_DIV8, GEAR_DIV16};

  clock_gear i_clock_gear (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_clock_en(system_clock_en), .peripheral_clock_en(peripheral_clock_en),
    .prescale_clock_en(prescale_clock_en), .clock_output_pin(clock_output_pin),
    .adc_clock_en(adc_clock_en)
  );

  // ==========================================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Ceiling is about ten times the expected run of about 2000 cycles
  always @(posedge pclk) begin
    n_cycle <= n_cycle + 1;
    if (n_cycle == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==========================================================================
  // Helpers
  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; an idle edge follows so psel is never set twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, what);
  endtask : rdchk

  // Write system control, then let the dividers settle before counting
  task setsys(input logic [31:0] d);
    apb(1'b1, `CG_SYSCTL_OFS, d);
    repeat (4) @(posedge pclk);
  endtask : setsys

  // Windows of 64 cycles hold a whole number of periods for every ratio
  task count(input int s, output int n);
    n = 0;
    repeat (64) begin
      @(posedge pclk);
      case (s)
        0: n += (system_clock_en === 1'b1);
        1: n += (peripheral_clock_en === 1'b1);
        2: n += (prescale_clock_en === 1'b1);
        default: n += (clock_output_pin === 1'b1);
      endcase
    end
  endtask : count

  function automatic logic [31:0] sysw(logic stop, logic [1:0] co, logic src, logic [2:0] pr,
      logic [2:0] gr);
    return {11'h000, stop, 2'b00, co, 3'b000, src, 1'b0, pr, 5'h00, gr};
  endfunction : sysw

  // ==========================================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(32'(adc_clock_en), 1, "adc clock after reset");
    rdchk(`CG_SYSCTL_OFS, `SYS_RESET, "system control reset");
    count(3, cnt);
    check(cnt, 32, "clock out half at reset");
    // Side registers: reset, storage, decode at own offset
    for (int i = 0; i < `CG_AUX_COUNT; i++) begin
      rdchk(aux_ofs[i], `AUX_RESET, "side register reset");
      apb(1'b1, aux_ofs[i], 32'h5A00_0000 + i);
    end
    for (int i = 0; i < `CG_AUX_COUNT; i++) begin
      rdchk(aux_ofs[i], 32'h5A00_0000 + i, "side register readback");
    end
    // Reserved places answer with an error and store nothing
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    check(32'(er), 1, "reserved write error");
    apb(1'b0, 12'h014, 32'h0000_0000);
    check({rd[30:0], er}, 1, "reserved read error");
    rdchk(`CG_SYSCTL_OFS, `SYS_RESET, "control untouched");
    // Spare and unused bits
    apb(1'b1, `CG_SYSCTL_OFS, 32'hFFFF_FFFF);
    rdchk(`CG_SYSCTL_OFS, `SYS_WR_MASK, "writable mask");
    // Gear ratios with the gear as peripheral source
    for (int i = 0; i < 5; i++) begin
      setsys(sysw(1'b0, CLKOUT_HALF, 1'b0, PRESC_DIV1, gear_codes[i]));
      count(0, cnt);
      check(cnt, 64 >> i, "gear pulses");
      count(1, cnt);
      check(cnt, 64 >> i, "peripheral from gear");
      count(3, cnt);
      check(cnt, 32 >> i, "clock out half");
    end
    // Undivided source ignores a slow gear
    setsys(sysw(1'b0, CLKOUT_FULL, 1'b1, PRESC_DIV1, GEAR_DIV16));
    count(1, cnt);
    check(cnt, 64, "peripheral undivided");
    count(3, cnt);
    check(cnt, 4, "clock out full");
    // Prescaler ratios on an every-cycle peripheral clock
    for (int i = 0; i < 6; i++) begin
      setsys(sysw(1'b0, CLKOUT_RSVD0, 1'b0, 3'(i), GEAR_DIV1));
      count(2, cnt);
      check(cnt, 64 >> i, "prescale pulses");
    end
    count(3, cnt);
    check(cnt, 0, "clock out reserved code");
    // Reserved gear and prescale codes run undivided; output code three stays low
    setsys(sysw(1'b0, CLKOUT_RSVD3, 1'b0, 3'h6, 3'h1));
    count(0, cnt);
    check(cnt, 64, "reserved gear code");
    count(2, cnt);
    check(cnt, 64, "reserved prescale code");
    count(3, cnt);
    check(cnt, 0, "clock out code three");
    // ADC clock gate stops and restarts; no conversion runs here, so stopping is safe
    setsys(sysw(1'b1, CLKOUT_HALF, 1'b0, PRESC_DIV1, GEAR_DIV1));
    check(32'(adc_clock_en), 0, "adc clock stopped");
    setsys(sysw(1'b0, CLKOUT_HALF, 1'b0, PRESC_DIV1, GEAR_DIV1));
    check(32'(adc_clock_en), 1, "adc clock restarted");
    stop_test();
  end
endmodule : tb
`default_nettype wire
